// ---- hdl/tws_if.sv ----
// pin-level link between memory controller and burst sram
`timescale 1ns/10ps
interface tws_if;
    logic kPos;
    logic kNeg;
    logic loadN;
    logic readNotWrite;
    logic [tws_pkg::ADDR_W-1:0] addr;
    logic [tws_pkg::BE_W-1:0] byteLaneSelN;
    logic [tws_pkg::DATA_W-1:0] ctrlDq;
    logic ctrlDqOe;
    logic [tws_pkg::DATA_W-1:0] devDq;
    logic devDqOe;
    logic [tws_pkg::DATA_W-1:0] dq;
    logic echoPos;
    logic echoNeg;
    logic outValidFlag;
    logic loopDisableN;

    // shared data wire level: device drive while devDqOe, else controller drive
    assign dq = devDqOe ? devDq : ctrlDq;

    modport ctrl (
        output kPos,
        output kNeg,
        output loadN,
        output readNotWrite,
        output addr,
        output byteLaneSelN,
        output ctrlDq,
        output ctrlDqOe,
        output loopDisableN,
        input dq,
        input echoPos,
        input echoNeg,
        input outValidFlag
    );
    modport dev (
        input kPos,
        input kNeg,
        input loadN,
        input readNotWrite,
        input addr,
        input byteLaneSelN,
        input dq,
        input loopDisableN,
        output devDq,
        output devDqOe,
        output echoPos,
        output echoNeg,
        output outValidFlag
    );
endinterface

// ---- hdl/tws_mem_ctrl.sv ----
// memory controller end: clock phases, command issue, write data, read capture
`timescale 1ns/10ps
module tws_mem_ctrl (
    input wire logic mclk,
    input wire logic nrst,
    tws_if.ctrl bus,
    input wire logic latencyTwo,
    input wire logic reqValid,
    input wire logic reqRead,
    input wire logic [tws_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [tws_pkg::DATA_W-1:0] reqData0,
    input wire logic [tws_pkg::DATA_W-1:0] reqData1,
    input wire logic [tws_pkg::BE_W-1:0] reqBeN0,
    input wire logic [tws_pkg::BE_W-1:0] reqBeN1,
    output logic rdReady,
    output logic wrReady,
    output logic rspValid,
    output logic [tws_pkg::DATA_W-1:0] rspData0,
    output logic [tws_pkg::DATA_W-1:0] rspData1
);
    logic kPos_q;
    logic kNeg_q;
    logic loadN_q;
    logic rnw_q;
    logic [tws_pkg::ADDR_W-1:0] addr_q;
    logic wrStage_q;
    logic [tws_pkg::DATA_W-1:0] st0_q;
    logic [tws_pkg::DATA_W-1:0] st1_q;
    logic [tws_pkg::BE_W-1:0] stBe0_q;
    logic [tws_pkg::BE_W-1:0] stBe1_q;
    logic [tws_pkg::DATA_W-1:0] hold1_q;
    logic [tws_pkg::BE_W-1:0] holdBe1_q;
    logic second_q;
    logic [tws_pkg::DATA_W-1:0] dqOut_q;
    logic dqOe_q;
    logic [tws_pkg::BE_W-1:0] beOut_q;
    logic [tws_pkg::NOP_W-1:0] nopLeft_q;
    logic rdReady_q;
    logic wrReady_q;
    logic got0_q;
    logic rspValid_q;
    logic [tws_pkg::DATA_W-1:0] rsp0_q;
    logic [tws_pkg::DATA_W-1:0] rsp1_q;
    logic loopDisableN_q;

    // slot: the edge at which K rises
    wire slot = !kPos_q;
    wire take = slot && reqValid && (reqRead ? rdReady_q : wrReady_q);
    wire takeWr = take && !reqRead;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            kPos_q <= 1'b0;
            kNeg_q <= 1'b0;
            loadN_q <= 1'b1;
            rnw_q <= 1'b1;
            addr_q <= tws_pkg::ADDR_RST;
            nopLeft_q <= '0;
            rdReady_q <= 1'b0;
            wrReady_q <= 1'b0;
            loopDisableN_q <= 1'b0;
        end else begin
            kPos_q <= !kPos_q;
            kNeg_q <= kPos_q;
            loopDisableN_q <= latencyTwo;
            if (slot) begin
                loadN_q <= !take;
                rnw_q <= reqRead;
                addr_q <= reqAddr;
                rdReady_q <= 1'b0;
                wrReady_q <= 1'b0;
                if (take && reqRead) begin
                    nopLeft_q <= tws_pkg::NOP_W'(tws_pkg::RW_NOPS);
                end else if (nopLeft_q != '0) begin
                    nopLeft_q <= tws_pkg::NOP_W'(nopLeft_q - 1'b1);
                end
            end else begin
                rdReady_q <= 1'b1;
                wrReady_q <= nopLeft_q == '0;
            end
        end
    end

    // write data one K after the command, word0 on K, word1 on K-bar
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wrStage_q <= 1'b0;
            st0_q <= tws_pkg::DATA_RST;
            st1_q <= tws_pkg::DATA_RST;
            stBe0_q <= tws_pkg::BE_NONE;
            stBe1_q <= tws_pkg::BE_NONE;
            hold1_q <= tws_pkg::DATA_RST;
            holdBe1_q <= tws_pkg::BE_NONE;
            second_q <= 1'b0;
            dqOut_q <= tws_pkg::DATA_RST;
            dqOe_q <= 1'b0;
            beOut_q <= tws_pkg::BE_NONE;
        end else if (slot) begin
            wrStage_q <= takeWr;
            if (takeWr) begin
                st0_q <= reqData0;
                st1_q <= reqData1;
                stBe0_q <= reqBeN0;
                stBe1_q <= reqBeN1;
            end
            hold1_q <= st1_q;
            holdBe1_q <= stBe1_q;
            second_q <= wrStage_q;
            dqOe_q <= wrStage_q;
            dqOut_q <= st0_q;
            beOut_q <= wrStage_q ? stBe0_q : tws_pkg::BE_NONE;
        end else begin
            second_q <= 1'b0;
            dqOut_q <= hold1_q;
            beOut_q <= second_q ? holdBe1_q : tws_pkg::BE_NONE;
        end
    end

    // read capture: word0 on the echo clock while the valid flag stands, word1 one cycle later
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            got0_q <= 1'b0;
            rspValid_q <= 1'b0;
            rsp0_q <= tws_pkg::DATA_RST;
            rsp1_q <= tws_pkg::DATA_RST;
        end else begin
            got0_q <= bus.echoPos && bus.outValidFlag;
            rspValid_q <= got0_q;
            if (bus.echoPos && bus.outValidFlag) begin
                rsp0_q <= bus.dq;
            end
            if (got0_q) begin
                rsp1_q <= bus.dq;
            end
        end
    end

    assign bus.kPos = kPos_q;
    assign bus.kNeg = kNeg_q;
    assign bus.loadN = loadN_q;
    assign bus.readNotWrite = rnw_q;
    assign bus.addr = addr_q;
    assign bus.byteLaneSelN = beOut_q;
    assign bus.ctrlDq = dqOut_q;
    assign bus.ctrlDqOe = dqOe_q;
    assign bus.loopDisableN = loopDisableN_q;
    assign rdReady = rdReady_q;
    assign wrReady = wrReady_q;
    assign rspValid = rspValid_q;
    assign rspData0 = rsp0_q;
    assign rspData1 = rsp1_q;
endmodule

// ---- hdl/tws_pkg.sv ----
// shared constants and types for the two-word burst sram port
package tws_pkg;
    localparam int DATA_W = 18;
    localparam int ADDR_W = 6;
    localparam int BE_W = 2;
    localparam int LANE_W = 9;
    localparam int LANE0_LSB = 0;
    localparam int LANE1_LSB = 9;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PLL_LOCK_US = 20;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLK_STOP_NS = 30;
    localparam int CLK_STOP_CYC = (CLK_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STOP_W = 4;
    localparam int LOCK_W = 16;
    localparam int IMP_PERIOD = 1024;
    localparam int IMP_W = 10;
    localparam int RW_NOPS = 2;
    localparam int NOP_W = 2;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;
    localparam logic [BE_W-1:0] BE_NONE = 2'h3;

    typedef enum logic [1:0] {
        TWS_PLL_OFF = 2'h0,
        TWS_PLL_WAIT = 2'h1,
        TWS_PLL_LOCK = 2'h2
    } tws_pll_t;
endpackage

// ---- hdl/tws_sram_dev.sv ----
// burst sram device end: command capture, posted writes, read pipeline
//
// Operation
// - write command loads write address register
// - first write word taken next K rise
// - second word on K-bar, commit 36 bits
// - new write accepted every K rise
// - finish pending write, then ignore inputs
// - byte selects sampled per data word
// - select0 gates [8:0], select1 gates [17:9]
// - controller puts two NOPs read-to-write
// - write after read held as posted write
// - same-address read returns pending write data
// - separate load per bank for depth
// - impedance update every 1024 cycles
// - free-running echo clocks follow input clocks
// - valid flag half cycle before data
// - pll locks after 20 us, stop resets
// - pll off gives one-cycle read latency
// - read data at t+2, K then K-bar
// - burst words at A then A+1
// - outputs off after reset and NOP
// - stopped clock holds previous output state
// - selects may change between burst halves
// - read command loads read address register
`timescale 1ns/10ps
module tws_sram_dev #(
    parameter int LOCK_CYC = tws_pkg::PLL_LOCK_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    tws_if.dev bus,
    output logic pllLocked,
    output logic impUpdate
);
    localparam int DEPTH = 1 << tws_pkg::ADDR_W;

    logic [tws_pkg::DATA_W-1:0] mem_q [DEPTH];
    logic [tws_pkg::ADDR_W-1:0] wrAddr_q;
    logic wrCmd_q;
    logic wrData0_q;
    logic [tws_pkg::ADDR_W-1:0] capAddr_q;
    logic [tws_pkg::DATA_W-1:0] cap0_q;
    logic [tws_pkg::BE_W-1:0] capBe0_q;
    logic pendValid_q;
    logic [tws_pkg::ADDR_W-1:0] pendAddr_q;
    logic [tws_pkg::DATA_W-1:0] pend0_q;
    logic [tws_pkg::DATA_W-1:0] pend1_q;
    logic [tws_pkg::BE_W-1:0] pendBe0_q;
    logic [tws_pkg::BE_W-1:0] pendBe1_q;
    logic rd1_q;
    logic rd2_q;
    logic [tws_pkg::ADDR_W-1:0] rdAddr1_q;
    logic [tws_pkg::ADDR_W-1:0] rdAddr2_q;
    logic [tws_pkg::ADDR_W-1:0] outAddr_q;
    logic secondWord_q;
    logic [tws_pkg::DATA_W-1:0] dqOut_q;
    logic dqOe_q;
    logic valid_q;
    logic echoPos_q;
    logic echoNeg_q;
    logic [tws_pkg::IMP_W-1:0] impCnt_q;
    logic impUpdate_q;
    tws_pkg::tws_pll_t pll_q;
    tws_pkg::tws_pll_t pll_d;
    logic [tws_pkg::STOP_W-1:0] stopCnt_q;
    logic [tws_pkg::LOCK_W-1:0] lockCnt_q;
    logic pllLocked_q;

    function automatic logic [tws_pkg::DATA_W-1:0] mergeWord(
        input logic [tws_pkg::DATA_W-1:0] old,
        input logic [tws_pkg::DATA_W-1:0] nw,
        input logic [tws_pkg::BE_W-1:0] beN
    );
        logic [tws_pkg::DATA_W-1:0] r;
        r = old;
        if (!beN[0]) begin
            r[tws_pkg::LANE0_LSB +: tws_pkg::LANE_W] = nw[tws_pkg::LANE0_LSB +: tws_pkg::LANE_W];
        end
        if (!beN[1]) begin
            r[tws_pkg::LANE1_LSB +: tws_pkg::LANE_W] = nw[tws_pkg::LANE1_LSB +: tws_pkg::LANE_W];
        end
        return r;
    endfunction

    function automatic logic [tws_pkg::ADDR_W-1:0] nextAddr(input logic [tws_pkg::ADDR_W-1:0] a);
        return tws_pkg::ADDR_W'(a + 1'b1);
    endfunction

    // array word with pending write laid over it
    function automatic logic [tws_pkg::DATA_W-1:0] readWord(input logic [tws_pkg::ADDR_W-1:0] a);
        logic [tws_pkg::DATA_W-1:0] r;
        r = mem_q[a];
        if (pendValid_q && pendAddr_q == a) begin
            r = mergeWord(r, pend0_q, pendBe0_q);
        end
        if (pendValid_q && nextAddr(pendAddr_q) == a) begin
            r = mergeWord(r, pend1_q, pendBe1_q);
        end
        return r;
    endfunction

    // command decode on K rise
    wire isWrite = bus.kPos && !bus.loadN && !bus.readNotWrite;
    wire isRead = bus.kPos && !bus.loadN && bus.readNotWrite;
    wire isNop = bus.kPos && bus.loadN;
    wire word1Now = bus.kNeg && wrData0_q;
    wire drainNow = isNop && pendValid_q && !wrCmd_q;
    wire commitNow = (word1Now || drainNow) && pendValid_q;
    wire latTwo = bus.loopDisableN;
    wire goSel = latTwo ? rd2_q : rd1_q;
    wire [tws_pkg::ADDR_W-1:0] addrSel = latTwo ? rdAddr2_q : rdAddr1_q;

    // array commit of the older record, two words at A and A+1
    always_ff @(posedge mclk) begin
        if (commitNow) begin
            mem_q[pendAddr_q] <= mergeWord(mem_q[pendAddr_q], pend0_q, pendBe0_q);
            mem_q[nextAddr(pendAddr_q)] <= mergeWord(mem_q[nextAddr(pendAddr_q)],
                pend1_q, pendBe1_q);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wrAddr_q <= tws_pkg::ADDR_RST;
            wrCmd_q <= 1'b0;
            wrData0_q <= 1'b0;
            capAddr_q <= tws_pkg::ADDR_RST;
            cap0_q <= tws_pkg::DATA_RST;
            capBe0_q <= tws_pkg::BE_NONE;
        end else begin
            if (bus.kPos) begin
                wrCmd_q <= isWrite;
                wrData0_q <= wrCmd_q;
                if (isWrite) begin
                    wrAddr_q <= bus.addr;
                end
                if (wrCmd_q) begin
                    capAddr_q <= wrAddr_q;
                    cap0_q <= bus.dq;
                    capBe0_q <= bus.byteLaneSelN;
                end
            end else if (bus.kNeg) begin
                wrData0_q <= 1'b0;
            end
        end
    end

    // pending record: replaced on each new burst, drained on NOP
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pendValid_q <= 1'b0;
            pendAddr_q <= tws_pkg::ADDR_RST;
            pend0_q <= tws_pkg::DATA_RST;
            pend1_q <= tws_pkg::DATA_RST;
            pendBe0_q <= tws_pkg::BE_NONE;
            pendBe1_q <= tws_pkg::BE_NONE;
        end else if (word1Now) begin
            pendValid_q <= 1'b1;
            pendAddr_q <= capAddr_q;
            pend0_q <= cap0_q;
            pendBe0_q <= capBe0_q;
            pend1_q <= bus.dq;
            pendBe1_q <= bus.byteLaneSelN;
        end else if (drainNow) begin
            pendValid_q <= 1'b0;
        end
    end

    // read pipeline and output registers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rd1_q <= 1'b0;
            rd2_q <= 1'b0;
            rdAddr1_q <= tws_pkg::ADDR_RST;
            rdAddr2_q <= tws_pkg::ADDR_RST;
            outAddr_q <= tws_pkg::ADDR_RST;
            secondWord_q <= 1'b0;
            dqOut_q <= tws_pkg::DATA_RST;
            dqOe_q <= 1'b0;
            valid_q <= 1'b0;
        end else if (bus.kPos) begin
            rd1_q <= isRead;
            rdAddr1_q <= bus.addr;
            rd2_q <= rd1_q;
            rdAddr2_q <= rdAddr1_q;
            if (goSel) begin
                dqOut_q <= readWord(addrSel);
                dqOe_q <= 1'b1;
                outAddr_q <= nextAddr(addrSel);
                secondWord_q <= 1'b1;
            end else begin
                dqOe_q <= 1'b0;
            end
        end else if (bus.kNeg) begin
            valid_q <= goSel;
            if (secondWord_q) begin
                dqOut_q <= readWord(outAddr_q);
                secondWord_q <= 1'b0;
            end
        end
    end

    // echo clocks line up with the output registers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            echoPos_q <= 1'b0;
            echoNeg_q <= 1'b0;
        end else begin
            echoPos_q <= bus.kPos;
            echoNeg_q <= bus.kNeg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            impCnt_q <= '0;
            impUpdate_q <= 1'b0;
        end else begin
            if (bus.kPos) begin
                impCnt_q <= tws_pkg::IMP_W'(impCnt_q + 1'b1);
            end
            impUpdate_q <= bus.kPos && impCnt_q == tws_pkg::IMP_W'(tws_pkg::IMP_PERIOD - 1);
        end
    end

    // pll lock tracking
    wire clkStopped = stopCnt_q >= tws_pkg::STOP_W'(tws_pkg::CLK_STOP_CYC);
    wire lockDone = lockCnt_q >= tws_pkg::LOCK_W'(LOCK_CYC - 1);

    always_comb begin
        pll_d = pll_q;
        case (pll_q)
            tws_pkg::TWS_PLL_OFF: begin
                if (bus.loopDisableN) begin
                    pll_d = tws_pkg::TWS_PLL_WAIT;
                end
            end
            tws_pkg::TWS_PLL_WAIT: begin
                if (lockDone && !clkStopped) begin
                    pll_d = tws_pkg::TWS_PLL_LOCK;
                end
            end
            tws_pkg::TWS_PLL_LOCK: begin
                if (clkStopped) begin
                    pll_d = tws_pkg::TWS_PLL_WAIT;
                end
            end
            default: pll_d = tws_pkg::TWS_PLL_OFF;
        endcase
        if (!bus.loopDisableN) begin
            pll_d = tws_pkg::TWS_PLL_OFF;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pll_q <= tws_pkg::TWS_PLL_OFF;
            stopCnt_q <= '0;
            lockCnt_q <= '0;
            pllLocked_q <= 1'b0;
        end else begin
            pll_q <= pll_d;
            pllLocked_q <= pll_d == tws_pkg::TWS_PLL_LOCK;
            if (bus.kPos || bus.kNeg) begin
                stopCnt_q <= '0;
            end else if (!clkStopped) begin
                stopCnt_q <= tws_pkg::STOP_W'(stopCnt_q + 1'b1);
            end
            if (pll_q != tws_pkg::TWS_PLL_WAIT || clkStopped) begin
                lockCnt_q <= '0;
            end else if (!lockDone) begin
                lockCnt_q <= tws_pkg::LOCK_W'(lockCnt_q + 1'b1);
            end
        end
    end

    assign bus.devDq = dqOut_q;
    assign bus.devDqOe = dqOe_q;
    assign bus.outValidFlag = valid_q;
    assign bus.echoPos = echoPos_q;
    assign bus.echoNeg = echoNeg_q;
    assign pllLocked = pllLocked_q;
    assign impUpdate = impUpdate_q;
endmodule

// ---- testbench/test_two_word_burst_sram_port.sv ----
// self-checking bench for the controller and sram pair
`timescale 1ns/10ps
module test_two_word_burst_sram_port;
    localparam int LOCK = 20;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic latencyTwo = 1'b1;
    logic reqValid = 1'b0;
    logic reqRead = 1'b0;
    logic [5:0] reqAddr = 6'h00;
    logic [17:0] reqData0 = 18'h00000;
    logic [17:0] reqData1 = 18'h00000;
    logic [1:0] reqBeN0 = 2'h3;
    logic [1:0] reqBeN1 = 2'h3;
    logic rdReady, wrReady, rspValid, pllLocked, impUpdate;
    logic [17:0] rspData0, rspData1;
    logic [17:0] mem [64];
    int errTotal = 0;
    int checks = 0;
    int cycles = 0;
    tws_if linkIf (); // one bank on its own load strobe
    tws_sram_dev #(.LOCK_CYC(LOCK)) tws_sram_dev_inst (.mclk(mclk), .nrst(nrst),
        .bus(linkIf), .pllLocked(pllLocked), .impUpdate(impUpdate));
    tws_mem_ctrl tws_mem_ctrl_inst (.mclk(mclk), .nrst(nrst), .bus(linkIf),
        .latencyTwo(latencyTwo), .reqValid(reqValid), .reqRead(reqRead), .reqAddr(reqAddr),
        .reqData0(reqData0), .reqData1(reqData1), .reqBeN0(reqBeN0), .reqBeN1(reqBeN1),
        .rdReady(rdReady), .wrReady(wrReady), .rspValid(rspValid), .rspData0(rspData0),
        .rspData1(rspData1));
    tws_monitor #(.LOCK_CYC(LOCK)) tws_monitor_inst (.mclk(mclk), .nrst(nrst),
        .kPos(linkIf.kPos), .kNeg(linkIf.kNeg), .loadN(linkIf.loadN),
        .readNotWrite(linkIf.readNotWrite), .ctrlDqOe(linkIf.ctrlDqOe),
        .devDqOe(linkIf.devDqOe), .echoPos(linkIf.echoPos), .echoNeg(linkIf.echoNeg),
        .outValidFlag(linkIf.outValidFlag), .loopDisableN(linkIf.loopDisableN),
        .pllLocked(pllLocked), .impUpdate(impUpdate));
    initial begin
        forever #2 mclk = ~mclk;
    end
    task automatic finishTest();
        $display("checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            errTotal = errTotal + 1;
            finishTest();
        end
    end
    task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
        checks++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // lane merge of one word, low select writes the lane
    function automatic logic [17:0] merge(input logic [17:0] o, n, input logic [1:0] b);
        return {b[1] ? o[17:9] : n[17:9], b[0] ? o[8:0] : n[8:0]};
    endfunction
    // issue one request and return at its take edge, valid left high
    task automatic doReq(input logic rd, input logic [5:0] a, input logic [17:0] d0, d1,
                         input logic [1:0] b0, b1);
        int n;
        reqValid <= 1'b1;
        reqRead <= rd;
        reqAddr <= a;
        reqData0 <= d0;
        reqData1 <= d1;
        reqBeN0 <= b0;
        reqBeN1 <= b1;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (!(linkIf.kPos === 1'b0 && (rd ? rdReady : wrReady) === 1'b1) && n < 40);
        @(posedge mclk);
        check("request taken", 18'h00001, {17'h00000, n < 40});
    endtask
    task automatic wr(input logic [5:0] a, input logic [17:0] d0, d1, input logic [1:0] b0, b1);
        doReq(1'b0, a, d0, d1, b0, b1);
        mem[a] = merge(mem[a], d0, b0);
        mem[a + 6'h01] = merge(mem[a + 6'h01], d1, b1);
    endtask
    task automatic rd(input logic [5:0] a, input int lat);
        int n;
        doReq(1'b1, a, 18'h00000, 18'h00000, 2'h3, 2'h3);
        reqValid <= 1'b0;
        // take edge counted as the first
        n = 1;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (rspValid !== 1'b1 && n < 20);
        check("read latency", 18'(lat), 18'(n));
        check("word at A", mem[a], rspData0);
        check("word at A+1", mem[a + 6'h01], rspData1);
        @(posedge mclk);
    endtask
    task automatic waitLock(input int lo);
        int n;
        n = 0;
        while (pllLocked !== 1'b1 && n < 60) begin
            @(posedge mclk);
            n++;
        end
        check("pll lock time ok", 18'h00001, {17'h00000, n >= lo && n <= LOCK + 4});
    endtask
    task automatic testBasic();
        wr(6'h05, 18'h2A5A5, 18'h15A5A, 2'h0, 2'h0);
        wr(6'h3F, 18'h3C3C3, 18'h03C3C, 2'h0, 2'h0);
        rd(6'h05, 8);
        rd(6'h3F, 8);
        $display("test basic done");
    endtask
    task automatic testLock();
        check("pll idle", 18'h00000, {17'h00000, pllLocked});
        waitLock(LOCK - 3);
        $display("test lock done");
    endtask
    task automatic testLanes();
        // known contents under both words first
        wr(6'h10, 18'h3FFFF, 18'h00000, 2'h0, 2'h0);
        for (int i = 0; i < 4; i++) begin
            wr(6'h10, 18'h12345 + 18'(i), 18'h2ABCD - 18'(i), i[1:0], ~i[1:0]);
            rd(6'h10, 8);
        end
        $display("test lanes done");
    endtask
    task automatic testPosted();
        wr(6'h20, 18'h11111, 18'h22222, 2'h0, 2'h0);
        rd(6'h20, 8);
        rd(6'h05, 8);
        rd(6'h20, 8);
        wr(6'h1F, 18'h33333, 18'h0CCCC, 2'h0, 2'h1);
        rd(6'h1F, 8);
        $display("test posted done");
    endtask
    // reads straight after a write, no NOP before the first fetch
    task automatic testBypass();
        wr(6'h28, 18'h2468A, 18'h13579, 2'h0, 2'h0);
        doReq(1'b1, 6'h28, 18'h00000, 18'h00000, 2'h3, 2'h3);
        doReq(1'b1, 6'h28, 18'h00000, 18'h00000, 2'h3, 2'h3);
        reqValid <= 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        check("bypass valid", 18'h00001, {17'h00000, rspValid});
        check("bypass word A", mem[6'h28], rspData0);
        check("bypass word A+1", mem[6'h29], rspData1);
        repeat (2) @(posedge mclk);
        #1;
        check("array valid", 18'h00001, {17'h00000, rspValid});
        check("array word A", mem[6'h28], rspData0);
        check("array word A+1", mem[6'h29], rspData1);
        @(posedge mclk);
        $display("test bypass done");
    endtask
    task automatic testLat1();
        latencyTwo <= 1'b0;
        repeat (4) @(posedge mclk);
        check("pll off", 18'h00000, {17'h00000, pllLocked});
        wr(6'h30, 18'h01234, 18'h3FEDC, 2'h0, 2'h0);
        rd(6'h30, 6);
        latencyTwo <= 1'b1;
        @(posedge mclk);
        waitLock(LOCK - 2);
        rd(6'h30, 8);
        $display("test latency done");
    endtask
    task automatic testImp();
        int n;
        n = 0;
        while (impUpdate !== 1'b1 && n < 2100) begin
            @(posedge mclk);
            n++;
        end
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (impUpdate !== 1'b1 && n < 2100);
        check("impedance period", 18'h00800, 18'(n));
        $display("test impedance done");
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        testLock();
        testBasic();
        testLanes();
        testPosted();
        testBypass();
        testLat1();
        testImp();
        finishTest();
    end
endmodule

// ---- testbench/tws_monitor.sv ----
// assertion checker on the controller to sram link
`timescale 1ns/10ps
module tws_monitor #(
    parameter int LOCK_CYC = tws_pkg::PLL_LOCK_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic kPos,
    input wire logic kNeg,
    input wire logic loadN,
    input wire logic readNotWrite,
    input wire logic ctrlDqOe,
    input wire logic devDqOe,
    input wire logic echoPos,
    input wire logic echoNeg,
    input wire logic outValidFlag,
    input wire logic loopDisableN,
    input wire logic pllLocked,
    input wire logic impUpdate
);
    logic [10:0] impCnt_q;
    logic [15:0] lockRun_q;
    wire rdCmd = kPos && !loadN && readNotWrite;
    wire wrCmd = kPos && !loadN && !readNotWrite;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // input clock rises since last impedance update
    always_ff @(posedge mclk) begin
        if (!nrst || impUpdate) begin
            impCnt_q <= 11'h000;
        end else if (kPos) begin
            impCnt_q <= impCnt_q + 11'h001;
        end
    end
    // cycles with the pll enabled
    always_ff @(posedge mclk) begin
        if (!nrst || !loopDisableN) begin
            lockRun_q <= 16'h0000;
        end else if (lockRun_q != 16'hFFFF) begin
            lockRun_q <= lockRun_q + 16'h0001;
        end
    end
    AST_ECHO: assert property (kPos |=> echoPos ##1 echoNeg)
        else $error("echo clocks out of step");
    AST_RD_LAT2: assert property (rdCmd && loopDisableN |-> ##5
        (devDqOe && echoPos && outValidFlag) ##1 (devDqOe && echoNeg))
        else $error("read data not at two-cycle latency");
    AST_RD_LAT1: assert property (rdCmd && !loopDisableN |-> ##3 devDqOe ##1 devDqOe)
        else $error("read data not at one-cycle latency");
    AST_WR_DATA: assert property (wrCmd |-> ##2 (ctrlDqOe && kPos && !devDqOe)
        ##1 (ctrlDqOe && kNeg))
        else $error("write data phase misplaced");
    AST_TURN: assert property (rdCmd |=> (!wrCmd) [*4])
        else $error("write too soon after read");
    AST_DRV_SRC: assert property ($rose(devDqOe) |-> $past(rdCmd, 5) || $past(rdCmd, 3))
        else $error("data driven without a read");
    AST_VALID: assert property ($rose(devDqOe) |-> $past(outValidFlag))
        else $error("valid flag not ahead of data");
    AST_IMP_AT: assert property (impUpdate |-> impCnt_q == 11'h400)
        else $error("impedance update off period");
    AST_IMP_DUE: assert property (impCnt_q <= 11'h400)
        else $error("impedance update missed");
    AST_PLL_OFF: assert property (!loopDisableN ##1 !loopDisableN |-> !pllLocked)
        else $error("pll locked while disabled");
    AST_PLL_LOCK: assert property ($rose(pllLocked) |-> int'(lockRun_q) + 2 >= LOCK_CYC)
        else $error("pll locked too early");
    AST_HOLD: assert property (!kPos && !kNeg |=> $stable(devDqOe) && $stable(outValidFlag))
        else $error("outputs moved with input clocks stopped");
endmodule
